// ---- rtl/btcd_cmp.sv ----
// Signal comparator: mismatch flag and lowest failing signal number
`timescale 1ns/1ps
module btcd_cmp #(
	parameter int NSIG = 100
) (
	input wire logic [NSIG-1:0] dut_sig,
	input wire logic [NSIG-1:0] ref_sig,
	output logic mismatch,
	output logic [7:0] err_idx
);

	logic [NSIG-1:0] diff;

	assign diff = dut_sig ^ ref_sig;
	assign mismatch = |diff;

	// Scan high to low so the lowest-numbered failing signal wins
	always_comb begin
		err_idx = 8'h00;
		for (int i = NSIG - 1; i >= 0; i--) begin
			if (diff[i]) begin
				err_idx = 8'(i);
			end
		end
	end

endmodule : btcd_cmp

// ---- rtl/btcd_map.svh ----
// Register offsets, field positions, codes and timing for the board test command decoder
`ifndef BTCD_MAP_SVH
`define BTCD_MAP_SVH

// Register offsets (byte addresses on the register port)
`define BTCD_CTRL_OFF 8'h00
`define BTCD_STATUS_OFF 8'h04
`define BTCD_FAIL_CMD_OFF 8'h08
`define BTCD_FAIL_TIME_OFF 8'h0C
`define BTCD_FAIL_ADDR_OFF 8'h10
`define BTCD_FAIL_CTX_OFF 8'h14
`define BTCD_CMD_BASE 8'h40

// Control bits (write one to act)
`define BTCD_CTRL_START 0
`define BTCD_CTRL_ABORT 1

// Status bits
`define BTCD_ST_BUSY 0
`define BTCD_ST_DONE 1
`define BTCD_ST_FAIL 2
`define BTCD_ST_INVALID 3
`define BTCD_ST_LOOP 4
`define BTCD_ST_UNSYNC 5

// Function digit codes (most significant BCD digit)
`define BTCD_FN_SEND 4'h6
`define BTCD_FN_PWO_A 4'h8
`define BTCD_FN_PWO_B 4'h9
`define BTCD_FN_INH_A 4'h7
`define BTCD_FN_INH_B 4'h1
`define BTCD_FN_LOOP 4'h4
`define BTCD_FN_END 4'h2

// Mode digit bit positions (bit 3 is ignored)
`define BTCD_MODE_STAT 0
`define BTCD_MODE_PRTOFF 1
`define BTCD_MODE_AUTODEC 2

// Report codes and limits
`define BTCD_ERR_INVALID 8'hEE
`define BTCD_UNSYNC_BIT 6'h37
`define BTCD_RDATA_RST 32'h0000_0000

// Timing in ns
`define BTCD_CLK_NS 4
`define BTCD_KEY_DOWN_NS 400
`define BTCD_KEY_UP_NS 400
`define BTCD_PWO_NS 2000

`endif

// ---- rtl/btcd_pkg.sv ----
// Types and the function digit decoder shared by the board test command decoder
`include "btcd_map.svh"
package btcd_pkg;

	// Sequencer states, Gray coded along idle-sync-fetch-key-release
	typedef enum logic [2:0] {
		BTCD_IDLE = 3'h0,
		BTCD_SYNC = 3'h1,
		BTCD_FETCH = 3'h3,
		BTCD_KEYDN = 3'h2,
		BTCD_KEYUP = 3'h6,
		BTCD_PWO = 3'h7,
		BTCD_DONE = 3'h5,
		BTCD_FAIL = 3'h4
	} btcd_state_e;

	// Actions a command can request
	typedef enum logic [2:0] {
		BTCD_ACT_SEND = 3'h0,
		BTCD_ACT_INHIBIT = 3'h1,
		BTCD_ACT_PWO = 3'h2,
		BTCD_ACT_LOOP = 3'h3,
		BTCD_ACT_END = 3'h4,
		BTCD_ACT_INVALID = 3'h5
	} btcd_act_e;

	// Function digit to action; anything undefined is rejected
	function automatic btcd_act_e btcd_decode(input logic [3:0] fdig);
		case (fdig)
			`BTCD_FN_SEND: btcd_decode = BTCD_ACT_SEND;
			`BTCD_FN_PWO_A, `BTCD_FN_PWO_B: btcd_decode = BTCD_ACT_PWO;
			`BTCD_FN_INH_A, `BTCD_FN_INH_B: btcd_decode = BTCD_ACT_INHIBIT;
			`BTCD_FN_LOOP: btcd_decode = BTCD_ACT_LOOP;
			`BTCD_FN_END: btcd_decode = BTCD_ACT_END;
			default: btcd_decode = BTCD_ACT_INVALID;
		endcase
	endfunction : btcd_decode

endpackage : btcd_pkg

// ---- rtl/btcd_sync.sv ----
// Two flip-flop synchroniser for the board-side pins
`timescale 1ns/1ps
module btcd_sync #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule : btcd_sync

// ---- rtl/btcd_top.sv ----
// Board test command decoder: command store, sequencer, comparison and failure report
`timescale 1ns/1ps
`include "btcd_map.svh"

//Contract
// - Each command is four BCD digits; the top digit picks the function.
// - Function 6 sends the keycode to both boards and compares them.
// - Function 8 or 9 drives the power-on reset pulse to the boards.
// - Function 7 or 1 applies the keycode with comparison inhibited.
// - Function 4 applies its keycode, then loops back to the command in slot 0.
// - Function 2 ends the test; no further commands run.
// - Second digit 4 gives automatic decimal, 2 printer off, held while keying.
// - Second digit top bit ignored; low bit marks the statistics keyblock.
// - The two low digits are the keycode applied to the boards.
// - A failure reports last command, keycode, word time and bit time.
// - Failure at command number 0 means the boards never synchronised.
// - A failure bit time above 55 flags probable loss of synchronisation.
// - Report holds previous address, current address, ROM group and active ROM.
// - Report holds the instruction stream type, shared or input/output only.
// - Report shows whether the last word select came from a ROM.
// - Report flags a storage to C register transfer in progress.
// - ROM field names one of eight ROMs: two quads of four.
// - Any compared signal mismatch stops the test and captures the failure.
// - The error number is the lowest-numbered failing signal.
module btcd_top #(
	parameter int NSIG = 100,
	parameter int WORD_W = 10,
	parameter int ADDR_W = 12,
	parameter int CMD_DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wstb,
	input wire logic reg_rstb,
	output logic [31:0] reg_rdata,
	output logic [7:0] key_code,
	output logic key_valid,
	output logic auto_decimal,
	output logic printer_off,
	output logic stat_block,
	output logic power_on_reset_pulse,
	input wire logic [NSIG-1:0] dut_sig,
	input wire logic [NSIG-1:0] ref_sig,
	input wire logic ref_sync,
	input wire logic [WORD_W-1:0] word_time,
	input wire logic [5:0] bit_time,
	input wire logic [ADDR_W-1:0] rom_addr,
	input wire logic [2:0] rom_group,
	input wire logic [2:0] rom_sel,
	input wire logic io_only_instruction_stream,
	input wire logic word_select_from_rom,
	input wire logic storage_to_c_transfer
);

	localparam int CTX_W = 2 * NSIG + WORD_W + ADDR_W + 16;
	localparam int IDX_W = $clog2(CMD_DEPTH);
	localparam logic [15:0] KEY_DOWN_CYC =
		16'((`BTCD_KEY_DOWN_NS + `BTCD_CLK_NS - 1) / `BTCD_CLK_NS);
	localparam logic [15:0] KEY_UP_CYC =
		16'((`BTCD_KEY_UP_NS + `BTCD_CLK_NS - 1) / `BTCD_CLK_NS);
	localparam logic [15:0] PWO_CYC = 16'((`BTCD_PWO_NS + `BTCD_CLK_NS - 1) / `BTCD_CLK_NS);

	logic [NSIG-1:0] dut_s;
	logic [NSIG-1:0] ref_s;
	logic ref_sync_s;
	logic [WORD_W-1:0] word_s;
	logic [5:0] bit_s;
	logic [ADDR_W-1:0] addr_s;
	logic [2:0] group_s;
	logic [2:0] rom_s;
	logic io_only_s;
	logic ws_rom_s;
	logic storage_to_c_transfer_s;
	logic [CTX_W-1:0] ctx_s;

	btcd_pkg::btcd_state_e state_q;
	btcd_pkg::btcd_act_e act_q;
	btcd_pkg::btcd_act_e cur_act;
	logic [15:0] cmd_mem [CMD_DEPTH];
	logic [15:0] cur_cmd;
	logic [15:0] cmd_q;
	logic [IDX_W-1:0] pc_q;
	logic [7:0] cmd_num_q;
	logic [15:0] cnt_q;
	logic last_slot;
	logic mismatch;
	logic [7:0] err_idx;
	logic cmp_en;
	logic fail_evt;
	logic start;
	logic abort;
	logic [7:0] cmd_off;
	logic cmd_hit;
	logic [IDX_W-1:0] wr_idx;
	logic [ADDR_W-1:0] cur_addr_q;
	logic [ADDR_W-1:0] last_addr_q;
	logic done_q;
	logic fail_q;
	logic invalid_q;
	logic loop_q;
	logic [7:0] f_num_q;
	logic [15:0] f_cmd_q;
	logic [WORD_W-1:0] f_word_q;
	logic [5:0] f_bit_q;
	logic [ADDR_W-1:0] f_last_q;
	logic [ADDR_W-1:0] f_cur_q;
	logic [7:0] f_err_q;
	logic [2:0] f_group_q;
	logic [2:0] f_rom_q;
	logic f_io_q;
	logic f_ws_q;
	logic f_storage_to_c_transfer_q;
	logic f_unsync;

	// Every board pin is asynchronous to clk_sys
	btcd_sync #(
		.W(CTX_W)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({dut_sig, ref_sig, ref_sync, word_time, bit_time, rom_addr, rom_group, rom_sel,
			io_only_instruction_stream, word_select_from_rom, storage_to_c_transfer}),
		.dout(ctx_s)
	);
	assign {dut_s, ref_s, ref_sync_s, word_s, bit_s, addr_s, group_s, rom_s,
		io_only_s, ws_rom_s, storage_to_c_transfer_s} = ctx_s;

	btcd_cmp #(
		.NSIG(NSIG)
	) u_cmp (
		.dut_sig(dut_s),
		.ref_sig(ref_s),
		.mismatch(mismatch),
		.err_idx(err_idx)
	);

	// Register port decode
	assign cmd_off = reg_addr - `BTCD_CMD_BASE;
	assign cmd_hit = (reg_addr >= `BTCD_CMD_BASE) && (int'(cmd_off[7:2]) < CMD_DEPTH)
		&& (cmd_off[1:0] == 2'h0);
	assign wr_idx = cmd_off[IDX_W+1:2];
	assign start = reg_wstb && (reg_addr == `BTCD_CTRL_OFF) && reg_wdata[`BTCD_CTRL_START];
	assign abort = reg_wstb && (reg_addr == `BTCD_CTRL_OFF) && reg_wdata[`BTCD_CTRL_ABORT];

	// Command store, one 4-digit command per word; the controller does the packing
	always_ff @(posedge clk_sys) begin
		if (reg_wstb && cmd_hit) begin
			cmd_mem[wr_idx] <= reg_wdata[15:0];
		end
	end

	assign cur_cmd = cmd_mem[pc_q];
	assign cur_act = btcd_pkg::btcd_decode(cur_cmd[15:12]);
	assign last_slot = (int'(pc_q) == CMD_DEPTH - 1);

	// Compare during sync (command 0) and around non-inhibited keycodes
	assign cmp_en = (state_q == btcd_pkg::BTCD_SYNC)
		|| (((state_q == btcd_pkg::BTCD_KEYDN) || (state_q == btcd_pkg::BTCD_KEYUP))
		&& ((act_q == btcd_pkg::BTCD_ACT_SEND) || (act_q == btcd_pkg::BTCD_ACT_LOOP)));
	assign fail_evt = (cmp_en && mismatch)
		|| ((state_q == btcd_pkg::BTCD_FETCH) && (cur_act == btcd_pkg::BTCD_ACT_INVALID));

	// Sequencer: one command at a time, in slot order except that a loop command returns to slot 0
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= btcd_pkg::BTCD_IDLE;
			act_q <= btcd_pkg::BTCD_ACT_END;
			cmd_q <= 16'h0000;
			pc_q <= '0;
			cmd_num_q <= 8'h00;
			cnt_q <= 16'h0000;
		end else if (abort) begin
			state_q <= btcd_pkg::BTCD_IDLE;
		end else if (start) begin
			state_q <= btcd_pkg::BTCD_SYNC;
			pc_q <= '0;
			cmd_num_q <= 8'h00;
		end else if (fail_evt) begin
			state_q <= btcd_pkg::BTCD_FAIL;
		end else begin
			case (state_q)
				btcd_pkg::BTCD_SYNC: begin
					if (ref_sync_s) begin
						state_q <= btcd_pkg::BTCD_FETCH;
					end
				end
				btcd_pkg::BTCD_FETCH: begin
					cmd_q <= cur_cmd;
					act_q <= cur_act;
					cmd_num_q <= 8'(pc_q) + 8'h01;
					case (cur_act)
						btcd_pkg::BTCD_ACT_PWO: begin
							state_q <= btcd_pkg::BTCD_PWO;
							cnt_q <= PWO_CYC;
						end
						btcd_pkg::BTCD_ACT_END: state_q <= btcd_pkg::BTCD_DONE;
						default: begin
							state_q <= btcd_pkg::BTCD_KEYDN;
							cnt_q <= KEY_DOWN_CYC;
						end
					endcase
				end
				btcd_pkg::BTCD_KEYDN: begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001) begin
						state_q <= btcd_pkg::BTCD_KEYUP;
						cnt_q <= KEY_UP_CYC;
					end
				end
				btcd_pkg::BTCD_KEYUP, btcd_pkg::BTCD_PWO: begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001) begin
						if (act_q == btcd_pkg::BTCD_ACT_LOOP) begin
							pc_q <= '0;
							state_q <= btcd_pkg::BTCD_FETCH;
						end else if (last_slot) begin
							state_q <= btcd_pkg::BTCD_DONE;
						end else begin
							pc_q <= pc_q + 1'b1;
							state_q <= btcd_pkg::BTCD_FETCH;
						end
					end
				end
				btcd_pkg::BTCD_IDLE, btcd_pkg::BTCD_DONE, btcd_pkg::BTCD_FAIL: begin
					state_q <= state_q;
				end
				default: state_q <= btcd_pkg::BTCD_IDLE;
			endcase
		end
	end

	// Keycode and mode lines, loaded at fetch so they hold for the whole key cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			key_code <= 8'h00;
			auto_decimal <= 1'b0;
			printer_off <= 1'b0;
			stat_block <= 1'b0;
		end else if (state_q == btcd_pkg::BTCD_FETCH && cur_act != btcd_pkg::BTCD_ACT_PWO
			&& cur_act != btcd_pkg::BTCD_ACT_END && !fail_evt && !abort && !start) begin
			key_code <= cur_cmd[7:0];
			auto_decimal <= cur_cmd[8+`BTCD_MODE_AUTODEC];
			printer_off <= cur_cmd[8+`BTCD_MODE_PRTOFF];
			stat_block <= cur_cmd[8+`BTCD_MODE_STAT];
		end else if (state_q != btcd_pkg::BTCD_KEYDN && state_q != btcd_pkg::BTCD_KEYUP) begin
			auto_decimal <= 1'b0;
			printer_off <= 1'b0;
			stat_block <= 1'b0;
		end
	end

	assign key_valid = (state_q == btcd_pkg::BTCD_KEYDN);
	assign power_on_reset_pulse = (state_q == btcd_pkg::BTCD_PWO);

	// Address history follows the reference board's program counter
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_addr_q <= '0;
			last_addr_q <= '0;
		end else if (addr_s != cur_addr_q) begin
			last_addr_q <= cur_addr_q;
			cur_addr_q <= addr_s;
		end
	end

	// Status flags; a start clears them, a new event in that cycle still sets
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			invalid_q <= 1'b0;
			loop_q <= 1'b0;
		end else begin
			if (start) begin
				done_q <= 1'b0;
				fail_q <= 1'b0;
				invalid_q <= 1'b0;
				loop_q <= 1'b0;
			end
			if (state_q == btcd_pkg::BTCD_FETCH && cur_act == btcd_pkg::BTCD_ACT_END
				&& !abort) begin
				done_q <= 1'b1;
			end
			if (fail_evt && !abort) begin
				fail_q <= 1'b1;
			end
			if (state_q == btcd_pkg::BTCD_FETCH && cur_act == btcd_pkg::BTCD_ACT_INVALID
				&& !abort) begin
				invalid_q <= 1'b1;
			end
			if (state_q == btcd_pkg::BTCD_FETCH && cur_act == btcd_pkg::BTCD_ACT_LOOP
				&& !abort) begin
				loop_q <= 1'b1;
			end
		end
	end

	// Failure snapshot; later mismatches cannot overwrite it since the test has stopped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			f_num_q <= 8'h00;
			f_cmd_q <= 16'h0000;
			f_word_q <= '0;
			f_bit_q <= 6'h00;
			f_last_q <= '0;
			f_cur_q <= '0;
			f_err_q <= 8'h00;
			f_group_q <= 3'h0;
			f_rom_q <= 3'h0;
			f_io_q <= 1'b0;
			f_ws_q <= 1'b0;
			f_storage_to_c_transfer_q <= 1'b0;
		end else if (fail_evt && !abort && !start) begin
			f_num_q <= (state_q == btcd_pkg::BTCD_FETCH) ? 8'(pc_q) + 8'h01 : cmd_num_q;
			f_cmd_q <= (state_q == btcd_pkg::BTCD_FETCH) ? cur_cmd : cmd_q;
			f_word_q <= word_s;
			f_bit_q <= bit_s;
			f_last_q <= last_addr_q;
			f_cur_q <= cur_addr_q;
			f_err_q <= (cmp_en && mismatch) ? err_idx : `BTCD_ERR_INVALID;
			f_group_q <= group_s;
			f_rom_q <= rom_s;
			f_io_q <= io_only_s;
			f_ws_q <= ws_rom_s;
			f_storage_to_c_transfer_q <= storage_to_c_transfer_s;
		end
	end

	assign f_unsync = fail_q && (f_bit_q > `BTCD_UNSYNC_BIT);

	// Read data stands only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= `BTCD_RDATA_RST;
		end else if (!reg_rstb) begin
			reg_rdata <= `BTCD_RDATA_RST;
		end else if (cmd_hit) begin
			reg_rdata <= {16'h0000, cmd_mem[wr_idx]};
		end else begin
			case (reg_addr)
				`BTCD_STATUS_OFF: begin
					reg_rdata <= {21'h000000, state_q, 2'h0, f_unsync, loop_q, invalid_q,
						fail_q, done_q, (state_q != btcd_pkg::BTCD_IDLE
						&& state_q != btcd_pkg::BTCD_DONE && state_q != btcd_pkg::BTCD_FAIL)};
				end
				`BTCD_FAIL_CMD_OFF: reg_rdata <= {f_cmd_q, 8'h00, f_num_q};
				`BTCD_FAIL_TIME_OFF: reg_rdata <= {10'h000, f_bit_q, 16'(f_word_q)};
				`BTCD_FAIL_ADDR_OFF: reg_rdata <= {16'(f_cur_q), 16'(f_last_q)};
				`BTCD_FAIL_CTX_OFF: begin
					reg_rdata <= {13'h0000, f_storage_to_c_transfer_q, f_ws_q, f_io_q, 2'h0, f_rom_q,
						f_group_q, f_err_q};
				end
				default: reg_rdata <= `BTCD_RDATA_RST;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_fetch(logic [3:0] fd);
		state_q == btcd_pkg::BTCD_FETCH && cur_cmd[15:12] == fd && !abort && !start;
	endsequence

	property p_send_compares;
		s_fetch(`BTCD_FN_SEND) ##0 !mismatch |=> state_q == btcd_pkg::BTCD_KEYDN && cmp_en;
	endproperty
	a_send_compares: assert property (p_send_compares) else $error("send not compared");

	property p_pwo_pulse;
		s_fetch(`BTCD_FN_PWO_B) |=> power_on_reset_pulse [*8];
	endproperty
	a_pwo_pulse: assert property (p_pwo_pulse) else $error("reset pulse missing");

	property p_inhibit;
		s_fetch(`BTCD_FN_INH_B) |=> key_valid && !cmp_en ##1 !cmp_en;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibited key compared");

	property p_end_holds;
		s_fetch(`BTCD_FN_END) |=> (state_q == btcd_pkg::BTCD_DONE && done_q) ##1
			(state_q == btcd_pkg::BTCD_DONE || $past(start) || $past(abort));
	endproperty
	a_end_holds: assert property (p_end_holds) else $error("end did not stop");

	property p_modes;
		key_valid |-> key_code == cmd_q[7:0] && auto_decimal == cmd_q[10]
			&& printer_off == cmd_q[9] && stat_block == cmd_q[8];
	endproperty
	a_modes: assert property (p_modes) else $error("key or mode lines wrong");

	property p_stop_on_mismatch;
		cmp_en && mismatch && !abort && !start |=> state_q == btcd_pkg::BTCD_FAIL
			&& f_err_q == $past(err_idx) && fail_q;
	endproperty
	a_stop_on_mismatch: assert property (p_stop_on_mismatch) else $error("mismatch missed");

	property p_cmd0;
		state_q == btcd_pkg::BTCD_SYNC && mismatch && !abort && !start |=> f_num_q == 8'h00;
	endproperty
	a_cmd0: assert property (p_cmd0) else $error("sync failure not command 0");

	property p_invalid;
		state_q == btcd_pkg::BTCD_FETCH && cur_act == btcd_pkg::BTCD_ACT_INVALID && !abort
			&& !start |=> invalid_q && f_err_q == `BTCD_ERR_INVALID && !key_valid;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid command ran");

	property p_unsync;
		reg_rstb && reg_addr == `BTCD_STATUS_OFF |=> reg_rdata[`BTCD_ST_UNSYNC]
			== ($past(fail_q) && ($past(f_bit_q) > 6'h37));
	endproperty
	a_unsync: assert property (p_unsync) else $error("unsync flag wrong");

	property p_in_order;
		state_q == btcd_pkg::BTCD_FETCH && !fail_evt && !abort && !start
			&& cur_act != btcd_pkg::BTCD_ACT_END |=> $stable(pc_q) [*2];
	endproperty
	a_in_order: assert property (p_in_order) else $error("command overlapped");

endmodule : btcd_top

// ---- test/btcd_boards.sv ----
// Behavioural pair of boards: a reference pattern and a board under test with injected faults
`timescale 1ns/1ps
module btcd_boards (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [99:0] fault_mask,
	input wire logic sync_ok,
	output logic [99:0] dut_sig,
	output logic [99:0] ref_sig,
	output logic ref_sync
);
	logic [99:0] pat_q;

	// Walking pattern so every compared line toggles and a stuck copy would be seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pat_q <= 100'h0;
		end else begin
			pat_q <= {pat_q[98:0], ~pat_q[99]};
		end
	end

	// The board under test only differs where the bench asks for a fault
	assign ref_sig = pat_q;
	assign dut_sig = pat_q ^ fault_mask;
	assign ref_sync = sync_ok; // Level held by the bench; low models a board that never locks
endmodule : btcd_boards

// ---- test/tb_btcd_top.sv ----
// Self-checking bench for the board test command decoder
`timescale 1ns/1ps
`include "btcd_map.svh"
module tb_btcd_top;
	typedef struct {
		logic [15:0] cmd;
		logic [7:0] fk;
		int kv;
		int pw;
		logic [31:0] st;
	} btcd_row_s;

	logic clk_sys, rst, reg_wstb, reg_rstb, key_valid, auto_decimal, printer_off, stat_block;
	logic power_on_reset_pulse, ref_sync, sync_ok, io_s, ws_rom, stc, kv_p;
	logic [7:0] reg_addr, key_code;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [99:0] dut_sig, ref_sig, fault_mask;
	logic [9:0] word_time;
	logic [5:0] bit_time;
	logic [11:0] rom_addr;
	logic [2:0] rom_group, rom_sel;
	logic [10:0] km;
	logic [7:0] ks [4];
	int errors, check_count, kv_n, pw_n;

	// Ordinary commands: word, faulted keycode (FF none), key cycles, reset cycles, status
	btcd_row_s rows [11] = '{
		'{16'h6023, 8'hFF, 100, 0, 32'h02},
		'{16'h6524, 8'hFF, 100, 0, 32'h02},
		'{16'h6226, 8'hFF, 100, 0, 32'h02},
		'{16'h6826, 8'hFF, 100, 0, 32'h02},
		'{16'h7073, 8'h73, 100, 0, 32'h02},
		'{16'h1034, 8'h34, 100, 0, 32'h02},
		'{16'h8000, 8'hFF, 0, 500, 32'h02},
		'{16'h9000, 8'hFF, 0, 500, 32'h02},
		'{16'h2000, 8'hFF, 0, 0, 32'h02},
		'{16'h3023, 8'hFF, 0, 0, 32'h2C},
		'{16'h5023, 8'hFF, 0, 0, 32'h2C}
	};

	btcd_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wstb(reg_wstb), .reg_rstb(reg_rstb), .reg_rdata(reg_rdata), .key_code(key_code),
		.key_valid(key_valid), .auto_decimal(auto_decimal), .printer_off(printer_off),
		.stat_block(stat_block), .power_on_reset_pulse(power_on_reset_pulse),
		.dut_sig(dut_sig), .ref_sig(ref_sig), .ref_sync(ref_sync), .word_time(word_time),
		.bit_time(bit_time), .rom_addr(rom_addr), .rom_group(rom_group), .rom_sel(rom_sel),
		.io_only_instruction_stream(io_s), .word_select_from_rom(ws_rom),
		.storage_to_c_transfer(stc));

	btcd_boards u_boards (.clk_sys(clk_sys), .rst(rst), .fault_mask(fault_mask),
		.sync_ok(sync_ok), .dut_sig(dut_sig), .ref_sig(ref_sig), .ref_sync(ref_sync));

	// Clock at 250 MHz
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wstb <= 1'h1;
		@(posedge clk_sys);
		reg_wstb <= 1'h0;
	endtask : wr

	// Read data stands only in the cycle after the strobe, so it is taken at that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rstb <= 1'h1;
		@(posedge clk_sys);
		reg_rstb <= 1'h0;
		@(posedge clk_sys);
		v = reg_rdata;
	endtask : rd

	// Load two slots, start, then watch a fixed window counting key and reset cycles
	task automatic run(input logic [15:0] c0, input logic [15:0] c1, input logic [7:0] fk,
		input int cyc);
		int n;
		wr(`BTCD_CMD_BASE, {16'h0000, c0});
		wr(`BTCD_CMD_BASE + 8'h04, {16'h0000, c1});
		wr(`BTCD_CTRL_OFF, 32'h0000_0001);
		kv_n = 0;
		pw_n = 0;
		n = 0;
		kv_p = 1'h0;
		repeat (cyc) begin
			@(posedge clk_sys);
			fault_mask <= ((key_valid && key_code == fk) || !sync_ok) ? 100'h1080 : 100'h0;
			if (key_valid && !kv_p && n < 4) begin
				ks[n] = key_code;
				n++;
			end
			if (key_valid) begin
				kv_n++;
				km = {auto_decimal, printer_off, stat_block, key_code};
			end
			if (power_on_reset_pulse) pw_n++;
			kv_p = key_valid;
		end
	endtask : run

	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test

	initial begin
		errors = 0;
		check_count = 0;
		rst = 1'h1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wstb = 1'h0;
		reg_rstb = 1'h0;
		sync_ok = 1'h1;
		fault_mask = 100'h0;
		word_time = 10'h2A5;
		bit_time = 6'h3A;
		rom_addr = 12'h000;
		rom_group = 3'h5;
		rom_sel = 3'h6;
		io_s = 1'h1;
		ws_rom = 1'h1;
		stc = 1'h1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
		// Reset values and an unmapped read
		rd(`BTCD_STATUS_OFF, d);
		chk("status after reset", 32'h0, d);
		rd(8'h80, d);
		chk("unmapped read", 32'h0, d);
		chk("outputs after reset", 32'h0, {30'h0, key_valid, power_on_reset_pulse});
		foreach (rows[i]) begin
			run(rows[i].cmd, rows[i].cmd == 16'h2000 ? 16'h6023 : 16'h2000, rows[i].fk, 1200);
			chk("key cycles", rows[i].kv, kv_n);
			chk("reset cycles", rows[i].pw, pw_n);
			if (rows[i].kv > 0) chk("key and modes", {21'h0, rows[i].cmd[10:0]}, {21'h0, km});
			rd(`BTCD_STATUS_OFF, d);
			chk("status", rows[i].st, d & 32'h3F);
			if (rows[i].st[3]) begin
				rd(`BTCD_FAIL_CTX_OFF, d);
				chk("invalid code", 32'hEE, d & 32'hFF);
			end
		end
		// Mismatch on the second command, lines 7 and 12 differ
		rom_addr <= 12'h123;
		repeat (4) @(posedge clk_sys);
		rom_addr <= 12'h456;
		run(16'h7073, 16'h6023, 8'h23, 1200);
		chk("key after stop", 32'h0, {31'h0, key_valid});
		rd(`BTCD_FAIL_CMD_OFF, d);
		chk("fail command", 32'h6023_0002, d);
		rd(`BTCD_FAIL_TIME_OFF, d);
		chk("fail time", 32'h003A_02A5, d);
		rd(`BTCD_FAIL_ADDR_OFF, d);
		chk("fail address", 32'h0456_0123, d);
		rd(`BTCD_FAIL_CTX_OFF, d);
		chk("fail context", 32'h0007_3507, d);
		chk("code in range", 32'h1, {31'h0, d[7:0] < 8'h64 || d[7:0] == 8'hEE});
		rd(`BTCD_STATUS_OFF, d);
		chk("fail status", 32'h24, d & 32'h3F);
		// Boards that never lock fail as command zero
		sync_ok <= 1'h0;
		bit_time <= 6'h10;
		run(16'h6023, 16'h2000, 8'hFF, 100);
		rd(`BTCD_FAIL_CMD_OFF, d);
		chk("unsynced command", 32'h0, d & 32'hFF);
		rd(`BTCD_STATUS_OFF, d);
		chk("unsynced status", 32'h04, d & 32'h3F);
		sync_ok <= 1'h1;
		// The unsynced run leaves the fault on; clear it so the next sync phase is clean
		fault_mask <= 100'h0;
		// Looping sequence closed by 4000, then aborted
		run(16'h6034, 16'h4000, 8'hFF, 1000);
		chk("loop keys", 32'h0034_0034, {8'h0, ks[0], ks[1], ks[2]});
		rd(`BTCD_STATUS_OFF, d);
		chk("looping status", 32'h11, d & 32'h11);
		wr(`BTCD_CTRL_OFF, 32'h0000_0002);
		rd(`BTCD_STATUS_OFF, d);
		chk("busy after abort", 32'h0, d & 32'h01);
		stop_test();
	end
endmodule : tb_btcd_top
